// ===== core/osdm_defines.svh
// Register offsets, field positions, reset values and timing counts of the status display
`ifndef OSDM_DEFINES_SVH
`define OSDM_DEFINES_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define OSDM_REG_VERSION   12'h000
`define OSDM_REG_STATUS    12'h004
`define OSDM_REG_IRQ_STAT  12'h008
`define OSDM_REG_IRQ_MASK  12'h00C
`define OSDM_REG_CTRL      12'h010

// ****************************************
// Field positions and reset values
// ****************************************
`define OSDM_CTRL_KEY_EN   0
`define OSDM_IRQ_ALARM     0
`define OSDM_IRQ_RESET     1
`define OSDM_IRQ_VERSION   2
// Version value shown by default; arbitrary value
`define OSDM_VERSION_RST   16'h0100
`define OSDM_CTRL_RST      1'h1
`define OSDM_MASK_RST      3'h0

// ****************************************
// Timing
// ****************************************
`define OSDM_CLK_HZ        50000000
`define OSDM_TICK_PER_S    1000
`define OSDM_TICK_CYC      (`OSDM_CLK_HZ / `OSDM_TICK_PER_S)
`define OSDM_HOLD_MS       11'd1000
`define OSDM_ACK_MS        11'd2000
`define OSDM_DEB_MS        4'd10
`define OSDM_BLINK_MS      9'd500
`define OSDM_ROT_MS        7'd100

// ****************************************
// Status codes
// ****************************************
`define OSDM_CODE_CTRL     4'h0
`define OSDM_CODE_MAIN     4'h2
`define OSDM_CODE_SETUP    4'h4
`define OSDM_CODE_SERVO    4'h8
`define OSDM_CODE_POLE     4'h9

`endif

// ===== core/osdm_pkg.sv
// Types of the operator status display controller
package osdm_pkg;

  // Panel view, one-hot
  typedef enum logic [4:0] {
    OSDM_V_STATUS    = 5'b00001,
    OSDM_V_RST_ASK   = 5'b00010,
    OSDM_V_RST_ACK   = 5'b00100,
    OSDM_V_VER_ASK   = 5'b01000,
    OSDM_V_VER_SHOW  = 5'b10000
  } osdm_view_e;

  // Indication shown on the segment display
  typedef enum logic [3:0] {
    OSDM_I_OFF       = 4'h0,
    OSDM_I_CTRL_PWR  = 4'h1,
    OSDM_I_MAIN_PWR  = 4'h2,
    OSDM_I_EST_READY = 4'h3,
    OSDM_I_EST_RUN   = 4'h4,
    OSDM_I_SETUP     = 4'h5,
    OSDM_I_SERVO     = 4'h6,
    OSDM_I_OT_CW     = 4'h7,
    OSDM_I_OT_CCW    = 4'h8,
    OSDM_I_REGEN     = 4'h9,
    OSDM_I_OVERLOAD  = 4'hA,
    OSDM_I_ALARM     = 4'hB,
    OSDM_I_RST_ASK   = 4'hC,
    OSDM_I_RST_ACK   = 4'hD,
    OSDM_I_VER_ASK   = 4'hE,
    OSDM_I_VER_SHOW  = 4'hF
  } osdm_ind_e;

  // Whole state of the controller
  typedef struct packed {
    osdm_view_e       view;
    osdm_ind_e        kind;
    logic [3:0]       code;
    logic [7:0]       alarm_code;
    logic [3:0]       alarm_stat;
    logic             alarm_seen;
    logic [15:0]      version;
    logic [15:0]      tick_cnt;
    logic [2:0]       key_stable;
    logic [2:0]       key_prev;
    logic [2:0][3:0]  deb_cnt;
    logic [10:0]      hold_ms;
    logic             hold_fired;
    logic [10:0]      ack_ms;
    logic [8:0]       blink_ms;
    logic [6:0]       rot_ms;
    logic             blink;
    logic [2:0]       phase;
    logic             clear_req;
    logic [2:0]       irq_stat;
    logic [2:0]       irq_mask;
    logic             key_en;
    logic             irq;
    logic [31:0]      prdata;
    logic             slverr;
  } osdm_state_s;

endpackage : osdm_pkg

// ===== core/osdm_core.sv
// Operator status display controller with key-hold menus and APB register slave
`include "osdm_defines.svh"

module osdm_core
  import osdm_pkg::*;
#(
  parameter int TICK_CYC = `OSDM_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        control_power_ok,
  input  wire logic        driver_ready,
  input  wire logic        main_power_ok,
  input  wire logic        prep_complete,
  input  wire logic        pole_est_ready,
  input  wire logic        pole_est_running,
  input  wire logic        pole_est_done,
  input  wire logic        setup_complete,
  input  wire logic        servo_on,
  input  wire logic        clockwise_limit,
  input  wire logic        counter_clockwise_limit,
  input  wire logic        regen_overload_warn,
  input  wire logic        overload_warn,
  input  wire logic        alarm_active,
  input  wire logic [7:0]  alarm_code,
  input  wire logic        alarm_needs_power_cycle,
  input  wire logic        key_mode,
  input  wire logic        key_write,
  input  wire logic        key_sub,
  output logic      [3:0]  disp_kind,
  output logic      [3:0]  disp_status_code,
  output logic      [7:0]  disp_alarm_code,
  output logic      [3:0]  disp_alarm_status,
  output logic      [15:0] disp_version,
  output logic             disp_blink,
  output logic      [2:0]  disp_phase,
  output logic             alarm_clear_req,
  output logic             irq
);

  osdm_state_s st_q;
  osdm_state_s st_d;

  logic        tick;
  logic [2:0]  key_raw;
  logic        mode_press;
  logic        hold_long;
  logic [3:0]  norm_code;
  osdm_ind_e   norm_kind;
  osdm_ind_e   stat_kind;
  logic        wr_acc;
  logic        rd_setup;
  logic [2:0]  irq_set;

  // ****************************************
  // Key timing and status decode
  // ****************************************

  // Raw keys, masked when panel is disabled
  assign key_raw    = st_q.key_en ? {key_sub, key_write, key_mode} : 3'h0;
  assign tick       = (st_q.tick_cnt == 16'(TICK_CYC - 1));
  assign mode_press = st_q.key_stable[0] & ~st_q.key_prev[0];
  // strictly longer than the hold time, once per press
  assign hold_long  = (st_q.hold_ms > `OSDM_HOLD_MS) & ~st_q.hold_fired;

  // Normal driver status, highest stage first
  always_comb begin
    norm_code = `OSDM_CODE_CTRL;
    norm_kind = OSDM_I_OFF;
    if (servo_on) begin
      norm_code = `OSDM_CODE_SERVO;
      norm_kind = OSDM_I_SERVO;
    end else if (pole_est_done && setup_complete) begin
      norm_code = `OSDM_CODE_SETUP;
      norm_kind = OSDM_I_SETUP;
    end else if (pole_est_running) begin
      norm_code = `OSDM_CODE_POLE;
      norm_kind = OSDM_I_EST_RUN;
    end else if (main_power_ok && pole_est_ready) begin
      norm_code = `OSDM_CODE_POLE;
      norm_kind = OSDM_I_EST_READY;
    end else if (main_power_ok) begin
      norm_code = `OSDM_CODE_MAIN;
      norm_kind = OSDM_I_MAIN_PWR;
    end else if (control_power_ok && driver_ready) begin
      norm_code = `OSDM_CODE_CTRL;
      norm_kind = OSDM_I_CTRL_PWR;
    end
  end

  // alarm, then warnings, then over-travel, then status
  always_comb begin
    if (alarm_active) begin
      stat_kind = OSDM_I_ALARM;
    end else if (regen_overload_warn) begin
      stat_kind = OSDM_I_REGEN;
    end else if (overload_warn) begin
      stat_kind = OSDM_I_OVERLOAD;
    end else if (clockwise_limit) begin
      // each limit has its own page
      stat_kind = OSDM_I_OT_CW;
    end else if (counter_clockwise_limit) begin
      stat_kind = OSDM_I_OT_CCW;
    end else begin
      stat_kind = norm_kind;
    end
  end

  // APB phase strobes
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d           = st_q;
    st_d.clear_req = 1'b0;
    irq_set        = 3'h0;

    st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;

    // debounce, a key must stay changed for the debounce time
    for (int k = 0; k < 3; k++) begin
      if (key_raw[k] == st_q.key_stable[k]) begin
        st_d.deb_cnt[k] = 4'h0;
      end else if (tick) begin
        if (st_q.deb_cnt[k] == `OSDM_DEB_MS - 4'd1) begin
          st_d.key_stable[k] = key_raw[k];
          st_d.deb_cnt[k]    = 4'h0;
        end else begin
          st_d.deb_cnt[k] = st_q.deb_cnt[k] + 4'h1;
        end
      end
    end
    st_d.key_prev = st_q.key_stable;

    // hold time restarts on any key change
    if (st_q.key_stable != st_q.key_prev) begin
      st_d.hold_ms    = 11'h000;
      st_d.hold_fired = 1'b0;
    end else if (tick && (st_q.key_stable != 3'h0) && (st_q.hold_ms != 11'h7FF)) begin
      st_d.hold_ms = st_q.hold_ms + 11'h001;
    end
    if (hold_long) begin
      st_d.hold_fired = 1'b1;
    end

    // Animation: blink and rotation phase
    if (tick) begin
      st_d.blink_ms = st_q.blink_ms + 9'h001;
      st_d.rot_ms   = st_q.rot_ms + 7'h01;
      if (st_q.blink_ms == `OSDM_BLINK_MS - 9'd1) begin
        st_d.blink_ms = 9'h000;
        st_d.blink    = ~st_q.blink;
      end
      if (st_q.rot_ms == `OSDM_ROT_MS - 7'd1) begin
        st_d.rot_ms = 7'h00;
        st_d.phase  = st_q.phase + 3'h1;
      end
    end

    // latch alarm code and status code at onset
    st_d.alarm_seen = alarm_active;
    if (alarm_active && !st_q.alarm_seen) begin
      st_d.alarm_code = alarm_code;
      st_d.alarm_stat = st_q.code;
      irq_set[`OSDM_IRQ_ALARM] = 1'b1;
    end

    // Panel view sequencing
    case (st_q.view)
      OSDM_V_STATUS: begin
        if (hold_long && st_q.key_stable == 3'b001 && alarm_active) begin
          st_d.view = OSDM_V_RST_ASK;
        end else if (hold_long && st_q.key_stable == 3'b100) begin
          st_d.view = OSDM_V_VER_ASK;
        end
      end
      OSDM_V_RST_ASK: begin
        if (hold_long && st_q.key_stable == 3'b010) begin
          st_d.view   = OSDM_V_RST_ACK;
          st_d.ack_ms = 11'h000;
          st_d.clear_req = ~alarm_needs_power_cycle;
          irq_set[`OSDM_IRQ_RESET] = 1'b1;
        end else if (mode_press) begin
          st_d.view = OSDM_V_STATUS;
        end
      end
      OSDM_V_RST_ACK: begin
        // acknowledge held for the full period
        if (tick) begin
          st_d.ack_ms = st_q.ack_ms + 11'h001;
        end
        // back to status page, which shows the alarm if it stayed
        // Strictly past the count, so a partial first tick never shortens it
        if (st_q.ack_ms > `OSDM_ACK_MS) begin
          st_d.view = OSDM_V_STATUS;
        end
      end
      OSDM_V_VER_ASK: begin
        if (hold_long && st_q.key_stable == 3'b010) begin
          st_d.view = OSDM_V_VER_SHOW;
          irq_set[`OSDM_IRQ_VERSION] = 1'b1;
        end else if (mode_press) begin
          st_d.view = OSDM_V_STATUS;
        end
      end
      OSDM_V_VER_SHOW: begin
        if (mode_press) begin
          st_d.view = OSDM_V_VER_ASK;
        end
      end
      default: begin
        st_d.view = OSDM_V_STATUS;
      end
    endcase

    // Registered display outputs
    st_d.code = norm_code;
    case (st_d.view)
      OSDM_V_RST_ASK:  st_d.kind = OSDM_I_RST_ASK;
      OSDM_V_RST_ACK:  st_d.kind = OSDM_I_RST_ACK;
      OSDM_V_VER_ASK:  st_d.kind = OSDM_I_VER_ASK;
      OSDM_V_VER_SHOW: st_d.kind = OSDM_I_VER_SHOW;
      default:         st_d.kind = stat_kind;
    endcase
    // rotation starts from its first glyph on entry
    if (st_d.kind != st_q.kind) begin
      st_d.phase  = 3'h0;
      st_d.rot_ms = 7'h00;
    end

    // Register writes take effect in the access phase
    if (wr_acc) begin
      case (paddr)
        `OSDM_REG_VERSION:  st_d.version  = pwdata[15:0];
        `OSDM_REG_IRQ_STAT: st_d.irq_stat = st_q.irq_stat & ~pwdata[2:0];
        `OSDM_REG_IRQ_MASK: st_d.irq_mask = pwdata[2:0];
        `OSDM_REG_CTRL:     st_d.key_en   = pwdata[`OSDM_CTRL_KEY_EN];
        default:            st_d.key_en   = st_q.key_en;
      endcase
    end
    // Events win over a simultaneous clear
    st_d.irq_stat = st_d.irq_stat | irq_set;
    st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);

    // Read data and error captured in the setup phase
    if (rd_setup) begin
      st_d.slverr = 1'b0;
      case (paddr)
        `OSDM_REG_VERSION:  st_d.prdata = {16'h0000, st_q.version};
        `OSDM_REG_STATUS:   st_d.prdata = {6'h00, st_q.view, alarm_active, st_q.alarm_stat,
                                           st_q.alarm_code, st_q.code, st_q.kind};
        `OSDM_REG_IRQ_STAT: st_d.prdata = {29'h00000000, st_q.irq_stat};
        `OSDM_REG_IRQ_MASK: st_d.prdata = {29'h00000000, st_q.irq_mask};
        `OSDM_REG_CTRL:     st_d.prdata = {31'h00000000, st_q.key_en};
        default: begin
          st_d.prdata = 32'h00000000;
          st_d.slverr = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.view     <= OSDM_V_STATUS;
      st_q.kind     <= OSDM_I_OFF;
      st_q.version  <= `OSDM_VERSION_RST;
      st_q.irq_mask <= `OSDM_MASK_RST;
      st_q.key_en   <= `OSDM_CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready            = psel & penable;
  assign prdata            = st_q.prdata;
  assign pslverr           = st_q.slverr & psel & penable;
  assign disp_kind         = st_q.kind;
  assign disp_status_code  = st_q.code;
  assign disp_alarm_code   = st_q.alarm_code;
  assign disp_alarm_status = st_q.alarm_stat;
  assign disp_version      = st_q.version;
  // blink only on the estimation-ready page
  assign disp_blink        = st_q.blink & (st_q.kind == OSDM_I_EST_READY);
  assign disp_phase        = st_q.phase;
  assign alarm_clear_req   = st_q.clear_req;
  assign irq               = st_q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ver_shown;
    st_q.view == OSDM_V_VER_SHOW && mode_press;
  endsequence
  sequence s_back_prompt;
    st_q.view == OSDM_V_VER_ASK;
  endsequence

  a_code_servo: assert property (servo_on |=> st_q.code == 4'h8)
    else $error("servo on without code 8");
  a_code_setup: assert property (!servo_on && pole_est_done && setup_complete
    |=> st_q.code == 4'h4)
    else $error("setup complete without code 4");
  a_code_main: assert property (main_power_ok && !servo_on && !pole_est_running
    && !pole_est_ready && !(pole_est_done && setup_complete) |=> st_q.code == 4'h2)
    else $error("main power without code 2");
  a_code_ready: assert property (main_power_ok && pole_est_ready && !servo_on
    && !pole_est_running && !(pole_est_done && setup_complete) |=> st_q.code == 4'h9)
    else $error("estimation ready without code 9");
  a_alarm_first: assert property (alarm_active && st_d.view == OSDM_V_STATUS
    |=> st_q.kind == OSDM_I_ALARM)
    else $error("alarm not shown first");
  a_ot_cw: assert property (clockwise_limit && !alarm_active && !regen_overload_warn
    && !overload_warn && st_d.view == OSDM_V_STATUS |=> st_q.kind == OSDM_I_OT_CW)
    else $error("clockwise over-travel not shown");
  a_clear_gate: assert property (alarm_clear_req |-> !$past(alarm_needs_power_cycle))
    else $error("power-cycle alarm cleared from panel");
  a_rst_hold: assert property ($rose(st_q.view == OSDM_V_RST_ACK)
    |-> $past(st_q.hold_ms) > 11'd1000)
    else $error("reset executed on short hold");
  a_ack_time: assert property ($fell(st_q.view == OSDM_V_RST_ACK)
    |-> $past(st_q.ack_ms) > 11'd2000)
    else $error("acknowledge left early");
  a_ver_back: assert property (s_ver_shown |=> s_back_prompt)
    else $error("mode press did not return to prompt");
  a_tick_wrap: assert property (tick |=> st_q.tick_cnt == 16'h0000 ##1 !tick)
    else $error("tick divider out of step");

endmodule : osdm_core

// ===== tb/osdm_panel.sv
// Panel model: operator push keys held for a chosen time
module osdm_panel #(
  parameter int TK = 5
) (
  input  wire logic pclk,
  output logic      key_mode,
  output logic      key_write,
  output logic      key_sub
);
  timeunit 1ns;
  timeprecision 1ps;

  // Keys released at time zero
  initial begin
    key_mode  = 1'b0;
    key_write = 1'b0;
    key_sub   = 1'b0;
  end

  task automatic press(input int k, input int ms);
    @(posedge pclk);
    case (k)
      0: key_mode <= 1'b1;
      1: key_write <= 1'b1;
      default: key_sub <= 1'b1;
    endcase
    repeat (ms * TK) @(posedge pclk);
    key_mode  <= 1'b0;
    key_write <= 1'b0;
    key_sub   <= 1'b0;
    repeat (20 * TK) @(posedge pclk);
  endtask : press
endmodule : osdm_panel

// ===== tb/osdm_core_tb.sv
// Self-checking bench of the operator status display controller
`include "osdm_defines.svh"
module osdm_core_tb import osdm_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals and device
  // ****************************************
  localparam int TK = 5;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, s_err, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s_rd, rd;
  logic        control_power_ok, driver_ready, main_power_ok, prep_complete;
  logic        pole_est_ready, pole_est_running, pole_est_done, setup_complete;
  logic        servo_on, clockwise_limit, counter_clockwise_limit;
  logic        regen_overload_warn, overload_warn;
  logic        alarm_active, alarm_needs_power_cycle, key_mode, key_write, key_sub;
  logic [7:0]  alarm_code, disp_alarm_code;
  logic [3:0]  disp_kind, disp_status_code, disp_alarm_status;
  logic [15:0] disp_version;
  logic [2:0]  disp_phase;
  logic        disp_blink, alarm_clear_req, irq;
  logic [12:0] st;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          clr_cnt = 0;

  // Driver state lines from one vector
  assign {control_power_ok, driver_ready, main_power_ok, prep_complete, pole_est_ready,
          pole_est_running, pole_est_done, setup_complete, servo_on, clockwise_limit,
          counter_clockwise_limit, regen_overload_warn, overload_warn} = st;

  osdm_core #(.TICK_CYC(TK)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .control_power_ok, .driver_ready, .main_power_ok, .prep_complete,
    .pole_est_ready, .pole_est_running, .pole_est_done, .setup_complete, .servo_on,
    .clockwise_limit, .counter_clockwise_limit, .regen_overload_warn, .overload_warn,
    .alarm_active, .alarm_code, .alarm_needs_power_cycle, .key_mode, .key_write,
    .key_sub, .disp_kind, .disp_status_code, .disp_alarm_code, .disp_alarm_status,
    .disp_version, .disp_blink, .disp_phase, .alarm_clear_req, .irq
  );

  osdm_panel #(.TK(TK)) i_panel (.pclk, .key_mode, .key_write, .key_sub);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Bus answer and clear pulses taken at the edge
  always @(posedge pclk) begin
    s_rd  <= prdata;
    s_err <= pslverr;
    if (alarm_clear_req === 1'b1) clr_cnt <= clr_cnt + 1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wt

  task automatic key(input int k, input int ms);
    i_panel.press(k, ms);
    wt(0);
  endtask : key

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) error_cnt++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    rd  = s_rd;
    err = s_err;
  endtask : apb

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    apb(1'b0, `OSDM_REG_VERSION, 32'h0);
    chk("ver rst", rd, `OSDM_VERSION_RST);
    apb(1'b0, `OSDM_REG_CTRL, 32'h0);
    chk("ctrl rst", rd, `OSDM_CTRL_RST);
    apb(1'b0, `OSDM_REG_IRQ_MASK, 32'h0);
    chk("mask rst", rd, `OSDM_MASK_RST);
    apb(1'b0, 12'h014, 32'h0);
    chk("hole err", err, 1'b1);
    chk("hole rd", rd, 32'h0);
    apb(1'b1, `OSDM_REG_VERSION, 32'h0000_1234);
    apb(1'b0, `OSDM_REG_VERSION, 32'h0);
    chk("ver rw", rd, 32'h0000_1234);
    chk("ver disp", disp_version, 16'h1234);
  endtask : t_regs

  task automatic t_status();
    logic [12:0] v [10] = '{13'h1800, 13'h1C00, 13'h1D00, 13'h1C80, 13'h1E60,
                            13'h1E70, 13'h1E78, 13'h1E74, 13'h1E7A, 13'h1E75};
    logic [39:0] kd = 40'h123456789A;
    logic [39:0] cd = 40'h0299488888;
    logic [2:0]  p;
    logic        b;
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      st <= v[i];
      wt(3);
      chk("kind", disp_kind, kd[39-4*i -: 4]);
      chk("code", disp_status_code, cd[39-4*i -: 4]);
    end
    @(posedge pclk);
    st <= 13'h1D00;
    wt(250 * TK);
    b = disp_blink;
    wt(500 * TK);
    chk("blink", disp_blink, !b);
    @(posedge pclk);
    st <= 13'h1E70;
    wt(150 * TK);
    p = disp_phase;
    wt(100 * TK);
    chk("phase", disp_phase, 3'(p + 3'h1));
  endtask : t_status

  task automatic t_alarm(input logic pc, input logic [7:0] code);
    int c0;
    @(posedge pclk);
    st                      <= 13'h1E72;
    alarm_code              <= code;
    alarm_needs_power_cycle <= pc;
    alarm_active            <= 1'b1;
    apb(1'b1, `OSDM_REG_IRQ_MASK, 32'h1);
    wt(3);
    chk("alarm", disp_kind, 4'hB);
    chk("acode", disp_alarm_code, code);
    chk("astat", disp_alarm_status, 4'h8);
    chk("irq", irq, 1'b1);
    apb(1'b1, `OSDM_REG_IRQ_STAT, 32'h1);
    wt(2);
    chk("irq clr", irq, 1'b0);
    key(0, 500);
    chk("short", disp_kind, 4'hB);
    key(0, 1100);
    chk("ask", disp_kind, 4'hC);
    c0 = clr_cnt;
    key(1, 1100);
    chk("ack", disp_kind, 4'hD);
    chk("clear", clr_cnt - c0, !pc);
    @(posedge pclk);
    alarm_active <= pc;
    st           <= 13'h1E70;
    wt(1770 * TK);
    chk("ack hold", disp_kind, 4'hD);
    wt(200 * TK);
    chk("after", disp_kind, pc ? 4'hB : 4'h6);
    @(posedge pclk);
    alarm_active <= 1'b0;
    wt(3);
  endtask : t_alarm

  task automatic t_version();
    apb(1'b1, `OSDM_REG_IRQ_MASK, 32'h0);
    apb(1'b1, `OSDM_REG_CTRL, 32'h0);
    key(2, 1100);
    chk("locked", disp_kind, 4'h6);
    apb(1'b1, `OSDM_REG_CTRL, 32'h1);
    key(2, 1100);
    chk("ver ask", disp_kind, 4'hE);
    key(1, 1100);
    chk("ver show", disp_kind, 4'hF);
    chk("ver val", disp_version, 16'h1234);
    chk("masked", irq, 1'b0);
    apb(1'b0, `OSDM_REG_IRQ_STAT, 32'h0);
    chk("ver evt", rd[2], 1'b1);
    apb(1'b0, `OSDM_REG_STATUS, 32'h0);
    chk("status", rd, 32'h0208_C38F);
    key(0, 50);
    chk("back1", disp_kind, 4'hE);
    key(0, 50);
    chk("back2", disp_kind, 4'h6);
  endtask : t_version

  // Main sequence
  initial begin
    presetn                 = 1'b0;
    psel                    = 1'b0;
    penable                 = 1'b0;
    pwrite                  = 1'b0;
    paddr                   = 12'h000;
    pwdata                  = 32'h0;
    st                      = 13'h0;
    alarm_active            = 1'b0;
    alarm_code              = 8'h00;
    alarm_needs_power_cycle = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_status();
    t_alarm(1'b1, 8'h5A);
    t_alarm(1'b0, 8'hC3);
    t_version();
    summarize();
  end

  // Watchdog
  initial begin
    #1_800_000;
    error_cnt++;
    summarize();
  end
endmodule : osdm_core_tb
